/* hdl/tpcg_core.sv */
module tpcg_core #(
  parameter int unsigned SYNC_STAGES = tpcg_pkg::SYNC_STAGES
) (
  // Oscillator and module reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Asynchronous pins from the system
  input  wire logic             reset_request_n,
  input  wire logic             wait_request_in,
  input  wire logic             cycle_marker,
  // Phase clocks to the processor and half-rate oscillator output
  output tpcg_pkg::tpcg_clk_t   clocks,
  output logic                  osc_out,
  // Auxiliary outputs
  output logic                  status_strobe_n,
  output logic                  ready,
  output logic                  reset_out
);
  import tpcg_pkg::*;

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // Pin synchronisers; only the last stage is read
  logic [SYNC_STAGES-1:0] rst_sync;
  logic [SYNC_STAGES-1:0] wait_sync;
  logic [SYNC_STAGES-1:0] mark_sync;
  logic [SYNC_STAGES-1:0] next_rst_sync;
  logic [SYNC_STAGES-1:0] next_wait_sync;
  logic [SYNC_STAGES-1:0] next_mark_sync;

  always_comb begin
    next_rst_sync  = {rst_sync[SYNC_STAGES-2:0], ~reset_request_n};
    next_wait_sync = {wait_sync[SYNC_STAGES-2:0], wait_request_in};
    next_mark_sync = {mark_sync[SYNC_STAGES-2:0], cycle_marker};
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rst_sync  <= '0;
      wait_sync <= '0;
      mark_sync <= '0;
    end else begin
      rst_sync  <= next_rst_sync;
      wait_sync <= next_wait_sync;
      mark_sync <= next_mark_sync;
    end
  end

  // Divide-by-nine counter and phase decode
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  tpcg_clk_t        next_clocks;
  logic             next_osc_out;

  always_comb begin
    if (count == CNT_LAST) begin // R1
      next_count = '0;
    end else begin
      next_count = count + 4'h1;
    end
    // Decoding the next count keeps every output straight off a flop
    next_clocks.phi1 = (next_count >= PHI1_FIRST)
                     && (next_count <= PHI1_LAST); // R2
    next_clocks.phi2 = (next_count >= PHI2_FIRST)
                     && (next_count <= PHI2_LAST); // R2 R3
    next_clocks.phi2_ttl = next_clocks.phi2; // R4
    // Registered outputs cannot pass the raw clock; a half-rate toggle does
    next_osc_out = ~osc_out; // R12
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count   <= CNT_LAST;
      clocks  <= '0;
      osc_out <= 1'b0;
    end else begin
      count   <= next_count;
      clocks  <= next_clocks;
      osc_out <= next_osc_out;
    end
  end

  // Internal timing ticks: early tick on the unit about to start, delayed tick on the current unit
  logic early_phase_one_tick;
  logic delayed_phase_two_tick;

  always_comb begin
    early_phase_one_tick   = (next_count == EARLY_P1);
    delayed_phase_two_tick = (count == DELAYED_P2);
  end

  // Reset, ready and strobe flops
  logic next_ready;
  logic next_reset_out;
  logic next_status_strobe_n;

  always_comb begin
    next_ready     = ready;
    next_reset_out = reset_out;
    if (delayed_phase_two_tick) begin // R9 R13
      next_ready     = wait_sync[SYNC_STAGES-1]; // R8
      next_reset_out = rst_sync[SYNC_STAGES-1];
    end
    // Reset holds the strobe low so the controller resets too
    next_status_strobe_n = ~(reset_out // R7
      || (early_phase_one_tick && mark_sync[SYNC_STAGES-1])); // R5 R6
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ready           <= 1'b0;
      reset_out       <= 1'b1;
      status_strobe_n <= 1'b0;
    end else begin
      ready           <= next_ready;
      reset_out       <= next_reset_out;
      status_strobe_n <= next_status_strobe_n;
    end
  end

  // Checks
  nine_period_a: assert property (@(posedge clk) disable iff (!rstn) // R1
    $rose(clocks.phi1) |-> ##9 $rose(clocks.phi1))
    else $error("phase one period is not nine units");

  phi1_width_a: assert property (@(posedge clk) disable iff (!rstn) // R2
    $rose(clocks.phi1) |-> clocks.phi1 ##1 clocks.phi1 ##1 !clocks.phi1)
    else $error("phase one width is not two units");

  phi2_width_a: assert property (@(posedge clk) disable iff (!rstn) // R2
    $rose(clocks.phi2) |-> clocks.phi2[*5] ##1 !clocks.phi2)
    else $error("phase two width is not five units");

  phase_lead_a: assert property (@(posedge clk) disable iff (!rstn) // R3
    $rose(clocks.phi1) |-> ##2 $rose(clocks.phi2))
    else $error("phase two does not rise two units after phase one");

  no_overlap_a: assert property (@(posedge clk) disable iff (!rstn) // R3
    !(clocks.phi1 && clocks.phi2))
    else $error("phase clocks overlap");

  ttl_copy_a: assert property (@(posedge clk) disable iff (!rstn) // R4
    clocks.phi2_ttl == clocks.phi2)
    else $error("logic-level phase two differs from phase two");

  strobe_one_a: assert property (@(posedge clk) disable iff (!rstn) // R5
    ($fell(status_strobe_n) && !reset_out && !$past(reset_out))
      |-> ##1 status_strobe_n)
    else $error("status strobe wider than one unit");

  strobe_place_a: assert property (@(posedge clk) disable iff (!rstn) // R6
    (!status_strobe_n && !reset_out && !$past(reset_out))
      |-> ##1 $rose(clocks.phi1))
    else $error("status strobe not just before phase one");

  reset_strobe_a: assert property (@(posedge clk) disable iff (!rstn) // R7
    $past(reset_out) |-> !status_strobe_n)
    else $error("strobe not held low during reset");

  capture_edge_a: assert property (@(posedge clk) disable iff (!rstn) // R13
    ($changed(reset_out) || $changed(ready)) |-> $rose(clocks.phi2))
    else $error("reset or ready changed off the capture edge");

  ready_follow_a: assert property (@(posedge clk) disable iff (!rstn) // R9
    $rose(clocks.phi2) |-> ready == $past(wait_sync[SYNC_STAGES-1]))
    else $error("ready does not follow the captured wait request");

  // Counter checks guard the decode that every phase output relies on
  count_range_a: assert property (@(posedge clk) disable iff (!rstn) // R1
    count <= CNT_LAST)
    else $error("divider count left its range");

  count_step_a: assert property (@(posedge clk) disable iff (!rstn) // R1
    (count != CNT_LAST)
      |=> (count == $past(count) + 4'h1))
    else $error("divider count skipped a unit");

  count_wrap_a: assert property (@(posedge clk) disable iff (!rstn) // R1
    (count == CNT_LAST)
      |=> (count == '0))
    else $error("divider count did not wrap after the last unit");

  phi2_gap_a: assert property (@(posedge clk) disable iff (!rstn) // R2
    $fell(clocks.phi2) |-> (!clocks.phi1 && !clocks.phi2)
      ##1 (!clocks.phi1 && !clocks.phi2) ##1 clocks.phi1)
    else $error("gap after phase two is not two units");

  strobe_count_a: assert property (@(posedge clk) disable iff (!rstn) // R5
    (!status_strobe_n && !reset_out && !$past(reset_out))
      |-> (count == CNT_LAST))
    else $error("status strobe outside the last unit");

  strobe_cause_a: assert property (@(posedge clk) disable iff (!rstn) // R6
    ($fell(status_strobe_n) && !$past(reset_out))
      |-> $past(mark_sync[SYNC_STAGES-1]))
    else $error("status strobe without a cycle marker");

  // Pin-side checks reach past the synchroniser, not copies of its flops
  ready_rise_a: assert property (@(posedge clk) disable iff (!rstn) // R8
    $rose(ready)
      |-> $past(wait_request_in, SYNC_STAGES + 1))
    else $error("ready rose without a wait request pin high");

  ready_fall_a: assert property (@(posedge clk) disable iff (!rstn) // R8
    $fell(ready)
      |-> !$past(wait_request_in, SYNC_STAGES + 1))
    else $error("ready fell without a wait request pin low");

  reset_pin_a: assert property (@(posedge clk) disable iff (!rstn) // R9
    $rose(reset_out)
      |-> !$past(reset_request_n, SYNC_STAGES + 1))
    else $error("reset output rose without a reset request");

  reset_release_a: assert property (@(posedge clk) disable iff (!rstn) // R13
    $fell(reset_out)
      |-> ($rose(clocks.phi2) && !$past(rst_sync[SYNC_STAGES-1])))
    else $error("reset output released off a clean capture");

  osc_toggle_a: assert property (@(posedge clk) disable iff (!rstn) // R12
    $past(rstn)
      |-> (osc_out != $past(osc_out)))
    else $error("oscillator output missed a toggle");
endmodule

/* inc/tpcg_pkg.sv */
// Summary of operation
// R1: Oscillator divided by nine with a synchronous modulo-nine counter.
// R2: Each period decodes 2-5-2: phase one two units, phase two five.
// R3: Phase two rises two units after phase one; never both high.
// R4: A logic-level copy of phase two is driven aligned with it.
// R5: An active status strobe is low for exactly one oscillator unit.
// R6: Machine-cycle marker gated with early phase-one tick forms the strobe.
// R7: The status strobe is held low while the reset output is active.
// R8: Auxiliary logic gives reset output, status strobe and synchronised ready.
// R9: Reset and wait requests captured on delayed phase-two tick; reset high.
// R10: Far side presents requests four units before the capture edge.
// R11: Far side holds wait request four units after the strobe.
// R12: A buffered oscillator-derived output is brought out for system timing.
// R13: Reset output releases only on a capture edge, never asynchronously.
package tpcg_pkg;
  localparam int unsigned DIVIDE       = 9;
  localparam int unsigned CNT_W        = 4;
  localparam logic [3:0]  CNT_LAST     = 4'h8;
  // Phase one units 0..1, gap none, phase two units 2..6, gap 7..8
  localparam logic [3:0]  PHI1_FIRST   = 4'h0;
  localparam logic [3:0]  PHI1_LAST    = 4'h1;
  localparam logic [3:0]  PHI2_FIRST   = 4'h2;
  localparam logic [3:0]  PHI2_LAST    = 4'h6;
  // Early phase-one tick: the unit just before phase one rises
  localparam logic [3:0]  EARLY_P1     = 4'h8;
  // Delayed phase-two tick: capture so outputs change with phase two rising
  localparam logic [3:0]  DELAYED_P2   = 4'h1;
  localparam int unsigned SYNC_STAGES  = 2;
  localparam real         OSC_PERIOD_NS = 5.0;
  localparam int unsigned P1_UNITS     = 2;
  localparam int unsigned P2_UNITS     = 5;
  localparam int unsigned P1_TO_P2     = 2;

  typedef struct packed {
    logic phi1;
    logic phi2;
    logic phi2_ttl;
  } tpcg_clk_t;
endpackage

/* verification/tpcg_cpu_model.sv */
module tpcg_cpu_model (
  // Oscillator and phases
  input  wire logic                clk,
  input  wire tpcg_pkg::tpcg_clk_t clocks,
  // Bench control
  input  wire logic                mark_en,
  // Marker to the generator
  output logic                     cycle_marker
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpcg_pkg::*;
  initial cycle_marker = 1'h0;
  // Spans phase two, so it is settled long before the strobe decision
  always @(negedge clk) begin
    cycle_marker <= mark_en & clocks.phi2;
  end
endmodule

/* verification/two_phase_clock_generator_tb.sv */
module two_phase_clock_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tpcg_pkg::*;
  logic      clk = 1'h0, rstn = 1'h0, req_n = 1'h1;
  logic      wait_in = 1'h0, mark_en = 1'h0, p1;
  logic      osc_out, strobe_n, ready, reset_out, marker;
  tpcg_clk_t clocks;
  int        miscompares = 0, checks_done = 0, n;
  // Rows: {wait_in, mark_en}; ready follows wait_in, strobe follows marker
  logic [1:0] rows [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  tpcg_core #(.SYNC_STAGES(2)) u_dut (.clk(clk), .rstn(rstn),
    .reset_request_n(req_n), .wait_request_in(wait_in),
    .cycle_marker(marker), .clocks(clocks), .osc_out(osc_out),
    .status_strobe_n(strobe_n), .ready(ready), .reset_out(reset_out));
  tpcg_cpu_model u_cpu (.clk(clk), .clocks(clocks), .mark_en(mark_en),
    .cycle_marker(marker));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task check(input string name, input logic exp, input logic seen);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One full period from phase one rising, unit by unit
  task period(input logic rdy, input logic mk, input logic rst);
    logic osc;
    logic e2;
    n = 0;
    while (clocks.phi1 !== 1'h0 && n < 20) begin @(negedge clk); n++; end
    while (clocks.phi1 !== 1'h1 && n < 40) begin @(negedge clk); n++; end
    for (int u = 0; u < 9; u++) begin
      e2 = (u >= 2 && u <= 6);
      check("phi1", u < 2, clocks.phi1);
      check("phi2", e2, clocks.phi2);
      check("phi2_ttl", e2, clocks.phi2_ttl);
      check("strobe", !(rst || (mk && u == 8)), strobe_n);
      check("ready", rdy, ready);
      check("reset", rst, reset_out);
      if (u > 0) check("osc", ~osc, osc_out);
      osc = osc_out;
      @(negedge clk);
    end
    check("wrap", 1'h1, clocks.phi1);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    check("rst_out", 1'h1, reset_out);
    check("rst_strobe", 1'h0, strobe_n);
    rstn = 1'h1;
    repeat (27) @(negedge clk);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      {wait_in, mark_en} = rows[i];
      repeat (18) @(negedge clk);
      period(rows[i][1], rows[i][0], 1'h0);
      $display("row %0d done", i);
    end
    // Held reset request keeps strobe low for a whole period
    req_n = 1'h0;
    repeat (27) @(negedge clk);
    period(1'h0, 1'h0, 1'h1);
    // Release only at the capture edge, with phase two rising
    req_n = 1'h1;
    for (n = 0; n < 30 && reset_out !== 1'h0; n++) begin
      p1 = clocks.phi1;
      @(negedge clk);
    end
    check("rel_done", 1'h0, reset_out);
    check("rel_phi2", 1'h1, clocks.phi2);
    check("rel_edge", 1'h1, p1);
    $display("reset request test done");
    give_verdict;
  end
  initial begin
    #5000;
    miscompares++;
    give_verdict;
  end
endmodule
